/* File: hw/adaptive_comb_yc_separator.sv */
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/10ps
// How it works
// - two line stores give three adjacent lines at once.
// - middle line is reference, so output lags input by one line.
// - with combing off, stores pass coded luma and chroma unchanged.
// - oscillator trim output lets firmware lock clock to subcarrier.
// - notch and bandpass on lines; adaption picks two weights, one for luma, one for chroma.
// - weights blend signals in sixteenths, never hard switching.
// - luma and chroma gain registers scale the adaption weights.
// - booster select 0 moderate, 1 maximum transition enhancement.
// - chroma-follows-luma bit takes chroma weight from luma adaption.
// - five-bit limit caps luma combing, 0 none, 31 most.
// - rain suppressor disable bit, 1 off, 0 on.
// - two 8-bit converter samples taken every enabled cycle.
// - 64-step gain code sent to the input amplifier.
// - zero-decibel gain step is the reset step.
// - clamp code 68 codes to internal 16.
// - chroma bias 128 codes to internal 128.
// - luma span 149 converter codes maps to 224 internal.
// - chroma span 190 maps to 128 plus or minus 112.
// - 8-step monitor gain updates together with main gain.
// - oscillator trim saturates at plus or minus 150 ppm.
// - firmware closes clamp, gain and clock loops from status.
// - decoder told to use separate luma/chroma mode when combing.
module adaptive_comb_yc_separator (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] lumaAdcPin,
    input wire logic [7:0] chromaAdcPin,
    input wire logic hsyncPin,
    output logic [7:0] lumaOut,
    output logic [7:0] chromaOut,
    output logic decoderSepMode,
    output logic [5:0] agcStep,
    output logic [2:0] monitorGain,
    output logic [7:0] clampCode,
    output logic [8:0] dcoAdjust,
    output logic porchStrobe
);
    function automatic logic [7:0] sat8(input logic signed [21:0] v);
        logic [7:0] r;
        r = v[7:0];
        if (v < 0) r = 8'h00;
        else if (v > 22'sh0000FF) r = 8'hFF;
        return r;
    endfunction

    function automatic logic [7:0] codeSample(input logic [7:0] x, input logic [7:0] ofs,
                                              input logic [9:0] mul, input logic [7:0] base);
        logic signed [21:0] d;
        logic signed [21:0] p;
        d = $signed({14'h0000, x}) - $signed({14'h0000, ofs});
        p = d * $signed({12'h000, mul});
        p = (p >>> 8) + $signed({14'h0000, base});
        return sat8(p);
    endfunction

    function automatic logic [7:0] absDiff(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    function automatic logic signed [21:0] mix(input logic signed [21:0] base,
                                               input logic signed [21:0] alt, input logic [4:0] k);
        logic signed [21:0] t;
        t = (alt - base) * $signed({17'h00000, k});
        return base + (t >>> 4);
    endfunction

    function automatic logic [4:0] weight(input logic [7:0] act, input logic boost);
        logic [7:0] s;
        s = boost ? act >> comb_pkg::SH_MAX : act >> comb_pkg::SH_MODERATE;
        return (s >= 8'h10) ? 5'h00 : 5'h10 - s[4:0];
    endfunction

    function automatic logic [4:0] scaleK(input logic [4:0] w, input logic [4:0] g);
        logic [9:0] p;
        p = w * g;
        p = p >> 4;
        return (p > 10'h010) ? comb_pkg::K_FULL : p[4:0];
    endfunction

    function automatic logic signed [21:0] ext(input logic [7:0] x);
        return $signed({14'h0000, x});
    endfunction

    // ---------------- registers and bus ----------------
    logic [8:0] ctrl_reg, ctrl_next;
    logic [4:0] lumaGain_reg, lumaGain_next, chromaGain_reg, chromaGain_next;
    logic [5:0] agc_reg, agc_next;
    logic [2:0] mon_reg, mon_next;
    logic [7:0] clamp_reg, clamp_next;
    logic [8:0] dco_reg, dco_next;
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    logic [8:0] actCtrl_reg, actCtrl_next;
    logic [4:0] actLg_reg, actLg_next, actCg_reg, actCg_next;
    logic [10:0] lineLen_reg, lineLen_next;
    logic [7:0] porch_reg, porch_next;
    logic setup, wrAcc, lineStart;
    logic [10:0] addr_reg;
    logic [7:0] lumaS2;

    assign setup = psel && !penable;
    assign wrAcc = psel && penable && pwrite && ce;

    always_comb begin
        logic signed [9:0] dv;
        dv = 10'($signed(pwdata[8:0]));
        ctrl_next = ctrl_reg;
        lumaGain_next = lumaGain_reg;
        chromaGain_next = chromaGain_reg;
        agc_next = agc_reg;
        mon_next = mon_reg;
        clamp_next = clamp_reg;
        dco_next = dco_reg;
        rdata_next = rdata_reg;
        err_next = err_reg;
        actCtrl_next = actCtrl_reg;
        actLg_next = actLg_reg;
        actCg_next = actCg_reg;
        lineLen_next = lineLen_reg;
        porch_next = porch_reg;
        if (wrAcc && !err_reg) begin
            unique case (paddr)
                comb_pkg::REG_CTRL: ctrl_next = pwdata[8:0];
                comb_pkg::REG_GAIN: begin
                    lumaGain_next = pwdata[4:0];
                    chromaGain_next = pwdata[comb_pkg::GAIN_CHROMA +: 5];
                end
                comb_pkg::REG_AGC: begin
                    agc_next = pwdata[5:0];
                    mon_next = pwdata[comb_pkg::AGC_MON +: 3];
                end
                comb_pkg::REG_CLAMP: clamp_next = pwdata[7:0];
                comb_pkg::REG_DCO: begin
                    if (dv > $signed({1'b0, comb_pkg::DCO_MAX})) dco_next = comb_pkg::DCO_MAX;
                    else if (dv < $signed({1'b1, comb_pkg::DCO_MIN})) dco_next = comb_pkg::DCO_MIN;
                    else dco_next = pwdata[8:0];
                end
                default: ;
            endcase
        end
        if (setup) begin
            err_next = 1'b0;
            rdata_next = 32'h00000000;
            unique case (paddr)
                comb_pkg::REG_CTRL: rdata_next[8:0] = ctrl_reg;
                comb_pkg::REG_GAIN: begin
                    rdata_next[4:0] = lumaGain_reg;
                    rdata_next[comb_pkg::GAIN_CHROMA +: 5] = chromaGain_reg;
                end
                comb_pkg::REG_AGC: begin
                    rdata_next[5:0] = agc_reg;
                    rdata_next[comb_pkg::AGC_MON +: 3] = mon_reg;
                end
                comb_pkg::REG_CLAMP: rdata_next[7:0] = clamp_reg;
                comb_pkg::REG_DCO: rdata_next = {{23{dco_reg[8]}}, dco_reg};
                comb_pkg::REG_STATUS: begin
                    rdata_next[10:0] = lineLen_reg;
                    rdata_next[comb_pkg::STAT_PORCH +: 8] = porch_reg;
                end
                default: err_next = 1'b1;
            endcase
        end
        if (lineStart) begin
            actCtrl_next = ctrl_reg;
            actLg_next = lumaGain_reg;
            actCg_next = chromaGain_reg;
            lineLen_next = addr_reg;
        end
        if (addr_reg == comb_pkg::PORCH_SAMPLE) begin
            porch_next = lumaS2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl_reg <= comb_pkg::CTRL_RST;
            lumaGain_reg <= comb_pkg::KGAIN_RST;
            chromaGain_reg <= comb_pkg::KGAIN_RST;
            agc_reg <= comb_pkg::AGC_RST;
            mon_reg <= comb_pkg::MON_RST;
            clamp_reg <= comb_pkg::CLAMP_RST;
            dco_reg <= comb_pkg::DCO_RST;
            rdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
            actCtrl_reg <= comb_pkg::CTRL_RST;
            actLg_reg <= comb_pkg::KGAIN_RST;
            actCg_reg <= comb_pkg::KGAIN_RST;
            lineLen_reg <= 11'h000;
            porch_reg <= 8'h00;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
            lumaGain_reg <= lumaGain_next;
            chromaGain_reg <= chromaGain_next;
            agc_reg <= agc_next;
            mon_reg <= mon_next;
            clamp_reg <= clamp_next;
            dco_reg <= dco_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
            actCtrl_reg <= actCtrl_next;
            actLg_reg <= actLg_next;
            actCg_reg <= actCg_next;
            lineLen_reg <= lineLen_next;
            porch_reg <= porch_next;
        end
    end

    assign pready = psel && penable && ce;
    assign pslverr = pready && err_reg;
    assign prdata = rdata_reg;
    assign agcStep = agc_reg;
    assign monitorGain = mon_reg;
    assign clampCode = clamp_reg;
    assign dcoAdjust = dco_reg;
    assign decoderSepMode = actCtrl_reg[comb_pkg::CTRL_EN];

    // ---------------- input sampling and coding ----------------
    logic [7:0] lumaS1, chromaS1, chromaS2;
    logic hsS1, hsS2, hsS3;
    logic [10:0] addr_next, addrD_reg;
    logic [15:0] in_reg, in_next, a1_reg, a2_reg;
    logic [15:0] d1, d2, b2_reg, bP1_reg, bP2_reg;
    logic [7:0] lumaOut_next, chromaOut_next;
    logic strobe_next;

    assign lineStart = hsS2 && !hsS3;

    always_comb begin
        addr_next = addr_reg;
        if (lineStart) addr_next = 11'h000;
        else if (addr_reg != 11'h7FF) addr_next = addr_reg + 11'h001;
        in_next = {codeSample(lumaS2, comb_pkg::CLAMP_ADC, comb_pkg::LUMA_MUL, comb_pkg::CLAMP_INT),
                   codeSample(chromaS2, comb_pkg::BIAS_CODE, comb_pkg::CHROMA_MUL, comb_pkg::BIAS_CODE)};
        strobe_next = (addr_reg == comb_pkg::PORCH_SAMPLE);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            {lumaS1, lumaS2, chromaS1, chromaS2} <= 32'h00000000;
            {hsS1, hsS2, hsS3} <= 3'h0;
            addr_reg <= 11'h000;
            addrD_reg <= 11'h000;
            in_reg <= 16'h0000;
            a1_reg <= 16'h0000;
            a2_reg <= 16'h0000;
            b2_reg <= 16'h0000;
            bP1_reg <= 16'h0000;
            bP2_reg <= 16'h0000;
            porchStrobe <= 1'b0;
        end else if (ce) begin
            lumaS1 <= lumaAdcPin;
            lumaS2 <= lumaS1;
            chromaS1 <= chromaAdcPin;
            chromaS2 <= chromaS1;
            {hsS1, hsS2, hsS3} <= {hsyncPin, hsS1, hsS2};
            addr_reg <= addr_next;
            addrD_reg <= addr_reg;
            in_reg <= in_next;
            a1_reg <= in_reg;
            a2_reg <= a1_reg;
            b2_reg <= d1;
            bP1_reg <= b2_reg;
            bP2_reg <= bP1_reg;
            porchStrobe <= strobe_next;
        end
    end

    // first store gives the middle line, second the oldest
    line_delay u_store_mid (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .addr(addr_reg),
        .din(in_reg),
        .dout(d1)
    );

    line_delay u_store_old (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .addr(addrD_reg),
        .din(d1),
        .dout(d2)
    );

    // ---------------- adaption and soft mixing ----------------
    logic [4:0] wRaw, wChr, ky, kc, kyCap;
    logic signed [21:0] notchY, bpC, combY, combC, yMix, cMix;
    logic rainHit;

    always_comb begin
        notchY = (ext(b2_reg[15:8]) + ext(bP2_reg[15:8])) >>> 1;
        bpC = ext(b2_reg[15:8]) - notchY;
        combY = (ext(a2_reg[15:8]) + (ext(b2_reg[15:8]) <<< 1) + ext(d2[15:8])) >>> 2;
        combC = ext(b2_reg[15:8]) - combY;
        wRaw = weight(absDiff(a2_reg[15:8], d2[15:8]), actCtrl_reg[comb_pkg::CTRL_BOOST]);
        wChr = weight(absDiff(combY[7:0], b2_reg[15:8]), actCtrl_reg[comb_pkg::CTRL_BOOST]);
        rainHit = !actCtrl_reg[comb_pkg::CTRL_RAIN] &&
                  absDiff(b2_reg[15:8], notchY[7:0]) < comb_pkg::RAIN_TH;
        kyCap = comb_pkg::K_FULL - (actCtrl_reg[comb_pkg::CTRL_LUMA_COMB_LIMIT +: 5] >> 1);
        ky = scaleK(rainHit ? 5'h00 : wRaw, actLg_reg);
        if (ky > kyCap) ky = kyCap;
        kc = scaleK(actCtrl_reg[comb_pkg::CTRL_CC] ? wRaw : wChr, actCg_reg);
        yMix = mix(notchY, combY, ky);
        cMix = mix(bpC, combC, kc) + ext(comb_pkg::BIAS_CODE);
        if (actCtrl_reg[comb_pkg::CTRL_EN]) begin
            lumaOut_next = sat8(yMix);
            chromaOut_next = sat8(cMix);
        end else begin
            lumaOut_next = b2_reg[15:8];
            chromaOut_next = b2_reg[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            lumaOut <= 8'h00;
            chromaOut <= 8'h00;
        end else if (ce) begin
            lumaOut <= lumaOut_next;
            chromaOut <= chromaOut_next;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_monitor_with_agc: assert property (
        ce && (monitorGain != $past(monitorGain)) |-> $past(wrAcc) && $past(paddr) == comb_pkg::REG_AGC)
        else $error("monitor gain changed outside an gain write");
    chk_dco_bounded: assert property (
        $signed(dcoAdjust) <= $signed(comb_pkg::DCO_MAX) && $signed(dcoAdjust) >= $signed(comb_pkg::DCO_MIN))
        else $error("oscillator trim beyond limit");
    chk_decoder_mode: assert property (
        decoderSepMode == actCtrl_reg[comb_pkg::CTRL_EN])
        else $error("decoder mode differs from combing state");
    chk_settings_at_line: assert property (
        ce && actCtrl_reg != $past(actCtrl_reg) |-> $past(lineStart) && $past(ce))
        else $error("settings changed mid line");
    chk_bypass_path: assert property (
        ce && !actCtrl_reg[comb_pkg::CTRL_EN] |=> !ce || lumaOut == $past(b2_reg[15:8]))
        else $error("bypass did not carry middle line luma");
    chk_limit_cap: assert property (
        ky <= kyCap && (actCtrl_reg[comb_pkg::CTRL_LUMA_COMB_LIMIT +: 5] != 5'h00 || ky == scaleK(rainHit ? 5'h00 : wRaw, actLg_reg)))
        else $error("luma comb limit violated");
    chk_chroma_follows: assert property (
        actCtrl_reg[comb_pkg::CTRL_CC] |-> kc == scaleK(wRaw, actCg_reg))
        else $error("chroma weight not taken from luma adaption");
    chk_weight_soft: assert property (
        ky <= comb_pkg::K_FULL && kc <= comb_pkg::K_FULL)
        else $error("mix weight above full scale");
    chk_clamp_coding: assert property (
        ce && lumaS2 == comb_pkg::CLAMP_ADC |=> !ce || in_reg[15:8] == comb_pkg::CLAMP_INT)
        else $error("clamp level not coded to internal black");
    chk_bias_coding: assert property (
        ce && chromaS2 == comb_pkg::BIAS_CODE |=> !ce || in_reg[7:0] == comb_pkg::BIAS_CODE)
        else $error("chroma bias not coded to mid code");
endmodule

/* File: hw/comb_pkg.sv */
package comb_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_GAIN = 8'h04;
    localparam logic [7:0] REG_AGC = 8'h08;
    localparam logic [7:0] REG_CLAMP = 8'h0C;
    localparam logic [7:0] REG_DCO = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    // field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_BOOST = 1;
    localparam int CTRL_CC = 2;
    localparam int CTRL_RAIN = 3;
    localparam int CTRL_LUMA_COMB_LIMIT = 4;
    localparam int GAIN_CHROMA = 8;
    localparam int AGC_MON = 8;
    localparam int STAT_PORCH = 16;
    // reset values
    localparam logic [8:0] CTRL_RST = 9'h001;
    localparam logic [4:0] KGAIN_RST = 5'h10;
    localparam logic [5:0] AGC_RST = 6'h1B;
    localparam logic [2:0] MON_RST = 3'h3;
    localparam logic [7:0] CLAMP_RST = 8'h80;
    localparam logic [8:0] DCO_RST = 9'h000;
    // oscillator trim limits, in ppm
    localparam logic [8:0] DCO_MAX = 9'h096;
    localparam logic [8:0] DCO_MIN = 9'h16A;
    // sample coding
    localparam logic [7:0] CLAMP_ADC = 8'h44;
    localparam logic [7:0] CLAMP_INT = 8'h10;
    localparam logic [7:0] BIAS_CODE = 8'h80;
    localparam logic [9:0] LUMA_MUL = 10'h181;
    localparam logic [9:0] CHROMA_MUL = 10'h12E;
    // comb weights: full weight is 16/16
    localparam logic [4:0] K_FULL = 5'h10;
    localparam logic [7:0] RAIN_TH = 8'h04;
    localparam int SH_MODERATE = 3;
    localparam int SH_MAX = 4;
    // line store
    localparam int LINE_AW = 11;
    localparam int LINE_DEPTH = 2048;
    localparam int PAIR_W = 16;
    localparam logic [10:0] PORCH_SAMPLE = 11'h074;
endpackage

/* File: hw/line_delay.sv */
`timescale 1ns/10ps
module line_delay (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [comb_pkg::LINE_AW-1:0] addr,
    input wire logic [comb_pkg::PAIR_W-1:0] din,
    output logic [comb_pkg::PAIR_W-1:0] dout
);
    logic [comb_pkg::PAIR_W-1:0] mem [comb_pkg::LINE_DEPTH];
    logic [comb_pkg::PAIR_W-1:0] dout_next;

    // read before write: the word returned was stored one line earlier
    always_comb begin
        dout_next = ce ? mem[addr] : dout;
    end

    always_ff @(posedge clk_sys) begin
        if (ce) begin
            mem[addr] <= din;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dout <= '0;
        end else begin
            dout <= dout_next;
        end
    end
endmodule

/* File: tb/adaptive_comb_yc_separator_bench.sv */
`timescale 1ns/10ps
module adaptive_comb_yc_separator_bench;
    localparam int LINE_LEN = 150;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] lumaAdcPin;
    logic [7:0] chromaAdcPin;
    logic hsyncPin;
    logic [7:0] lumaOut;
    logic [7:0] chromaOut;
    logic decoderSepMode;
    logic [5:0] agcStep;
    logic [2:0] monitorGain;
    logic [7:0] clampCode;
    logic [8:0] dcoAdjust;
    logic porchStrobe;
    logic [7:0] lumaLevel = 8'h44;
    logic [7:0] chromaLevel = 8'h80;
    logic [10:0] vidIdx;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    int porchCount = 0;
    int seed = 32'h8254e543;
    int dv;
    int ex;
    int pc;
    logic [31:0] rd;
    logic err;
    logic [5:0] stp;
    logic [2:0] mg;
    logic [7:0] lv [0:5];
    logic [7:0] cv [0:5];
    logic [7:0] regAddr [0:4] = '{comb_pkg::REG_CTRL, comb_pkg::REG_GAIN, comb_pkg::REG_AGC,
        comb_pkg::REG_CLAMP, comb_pkg::REG_DCO};
    logic [31:0] regRst [0:4] = '{{23'h0, comb_pkg::CTRL_RST}, {19'h0, comb_pkg::KGAIN_RST, 3'h0,
        comb_pkg::KGAIN_RST}, {21'h0, comb_pkg::MON_RST, 2'h0, comb_pkg::AGC_RST},
        {24'h0, comb_pkg::CLAMP_RST}, 32'h0};
    logic [8:0] cfg [0:3] = '{9'h001, 9'h003, 9'h005, 9'h1F9};

    adaptive_comb_yc_separator dut_u (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lumaAdcPin(lumaAdcPin), .chromaAdcPin(chromaAdcPin),
        .hsyncPin(hsyncPin), .lumaOut(lumaOut), .chromaOut(chromaOut), .decoderSepMode(decoderSepMode),
        .agcStep(agcStep), .monitorGain(monitorGain), .clampCode(clampCode), .dcoAdjust(dcoAdjust),
        .porchStrobe(porchStrobe));
    video_source #(.LINE_LEN(LINE_LEN)) src_u (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .lumaLevel(lumaLevel), .chromaLevel(chromaLevel), .lumaAdcPin(lumaAdcPin),
        .chromaAdcPin(chromaAdcPin), .hsyncPin(hsyncPin), .vidIdx(vidIdx));

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (porchStrobe === 1'b1) porchCount <= porchCount + 1;
    end
    always @(posedge clk_sys) begin
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            finish_test();
        end
    end

    function automatic logic [7:0] lumaCode(input logic [7:0] v);
        return 8'((int'(v) - 68) * 385 / 256 + 16);
    endfunction
    function automatic logic [7:0] chromaCode(input logic [7:0] c);
        return 8'((int'(c) - 128) * 302 / 256 + 128);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitIdx(input int n);
        do @(posedge clk_sys); while (vidIdx !== 11'(n));
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        chk(32'(agcStep), 32'd27, "gain step after reset");
        chk(32'(decoderSepMode), 32'd1, "decoder mode after reset");
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, regAddr[i], 32'h0);
            chk(rd, regRst[i], "register reset value");
        end
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(err), 32'd1, "unmapped error");
        for (int i = 0; i < 4; i++) begin
            stp = 6'($random(seed));
            mg = 3'($random(seed));
            apb(1'b1, comb_pkg::REG_CLAMP, {24'h0, stp, mg[1:0]});
            apb(1'b1, comb_pkg::REG_AGC, {21'h0, mg, 2'h0, stp});
            apb(1'b0, comb_pkg::REG_AGC, 32'h0);
            chk(rd, {21'h0, mg, 2'h0, stp}, "gain readback");
            chk({29'h0, monitorGain}, {29'h0, mg}, "monitor gain");
            chk({26'h0, agcStep}, {26'h0, stp}, "main gain");
            chk({24'h0, clampCode}, {24'h0, stp, mg[1:0]}, "clamp code");
        end
        for (int i = 0; i < 4; i++) begin
            dv = (i == 0) ? 200 : (i == 1) ? -200 : (i == 2) ? 150 : $random(seed) % 151;
            ex = (dv > 150) ? 150 : (dv < -150) ? -150 : dv;
            apb(1'b1, comb_pkg::REG_DCO, 32'(dv));
            apb(1'b0, comb_pkg::REG_DCO, 32'h0);
            chk(rd, 32'(ex), "trim readback");
            chk({23'h0, dcoAdjust}, {23'h0, 9'(ex)}, "trim output");
        end
        waitIdx(20);
        apb(1'b1, comb_pkg::REG_CTRL, 32'h0);
        waitIdx(100);
        chk(32'(decoderSepMode), 32'd1, "mode changed mid-line");
        waitIdx(20);
        chk(32'(decoderSepMode), 32'd0, "mode at line start");
        for (int i = 0; i < 6; i++) begin
            waitIdx(20);
            lv[i] = 8'(68 + {$random(seed)} % 149);
            cv[i] = 8'(128 + {$random(seed)} % 108);
            lumaLevel <= lv[i];
            chromaLevel <= cv[i];
            waitIdx(75);
            if (i >= 2) begin
                chk({24'h0, lumaOut}, {24'h0, lumaCode(lv[i-2])}, "bypass luma");
                chk({24'h0, chromaOut}, {24'h0, chromaCode(cv[i-2])}, "bypass chroma");
            end
            if (i >= 1) begin
                waitIdx(130);
                apb(1'b0, comb_pkg::REG_STATUS, 32'h0);
                chk({24'h0, rd[23:16]}, {24'h0, lv[i-1]}, "porch sample");
                chk({21'h0, rd[10:0]}, 32'(LINE_LEN - 1), "line length");
            end
        end
        waitIdx(20);
        pc = porchCount;
        repeat (2) waitIdx(20);
        chk(32'(porchCount - pc), 32'd2, "porch pulses per line");
        chromaLevel <= comb_pkg::BIAS_CODE;
        for (int i = 0; i < 4; i++) begin
            waitIdx(20);
            apb(1'b1, comb_pkg::REG_CTRL, {23'h0, cfg[i]});
            apb(1'b1, comb_pkg::REG_GAIN, {19'h0, 5'({$random(seed)} % 17), 3'h0, 5'({$random(seed)} % 17)});
            lv[0] = 8'(68 + {$random(seed)} % 149);
            lumaLevel <= lv[0];
            repeat (3) waitIdx(20);
            waitIdx(75);
            chk({24'h0, lumaOut}, {24'h0, lumaCode(lv[0])}, "comb luma");
            chk({24'h0, chromaOut}, 32'h80, "comb chroma");
            chk(32'(decoderSepMode), 32'd1, "decoder mode in comb");
        end
        // freeze on the porch pulse: the one-cycle strobe must stand while ce is low
        waitIdx(119);
        ce <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(32'(porchStrobe), 32'd1, "strobe held while frozen");
        ce <= 1'b1;
        finish_test();
    end
endmodule

/* File: tb/video_source.sv */
`timescale 1ns/10ps
module video_source #(
    parameter int LINE_LEN = 150
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] lumaLevel,
    input wire logic [7:0] chromaLevel,
    output logic [7:0] lumaAdcPin,
    output logic [7:0] chromaAdcPin,
    output logic hsyncPin,
    output logic [10:0] vidIdx
);
    logic [10:0] idxNext;
    always_comb begin
        idxNext = (vidIdx == 11'(LINE_LEN - 1)) ? 11'h000 : vidIdx + 11'h001;
    end
    // one level per line keeps every sample of a line predictable
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            vidIdx <= 11'h000;
            lumaAdcPin <= 8'h00;
            chromaAdcPin <= 8'h00;
            hsyncPin <= 1'b0;
        end else if (ce) begin
            vidIdx <= idxNext;
            hsyncPin <= (idxNext < 11'h008);
            if (idxNext == 11'h000) begin
                lumaAdcPin <= lumaLevel;
                chromaAdcPin <= chromaLevel;
            end
        end
    end
endmodule
